// >>> sbp_pkg.sv
// package: constants and carrier types for the serial bus phy datapath core
package sbp_pkg;
   // register offsets (host side byte address bus)
   localparam logic [11:0] HC_CTRL_OFS = 12'h050;
   localparam logic [11:0] HC_CTRL_SET_OFS = 12'h050;
   localparam logic [11:0] HC_CTRL_CLR_OFS = 12'h054;
   localparam logic [11:0] VSE_OFS = 12'ha88;
   // field positions
   localparam int LPR_BIT = 19;
   localparam int VSE_TS_BIT = 0;
   localparam int VSE_STRIP_BIT = 1;
   // reset values
   localparam logic [31:0] HC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] VSE_RST = 32'h0000_0000;
   // timing
   localparam int SYS_CLK_KHZ = 40000;
   localparam int WAKE_MAX_US = 2000;
   localparam int WAKE_CYC = (WAKE_MAX_US * (SYS_CLK_KHZ / 1000)) / 2;
   localparam int LINK_DIV = 8;
   localparam int CIP_QUADS = 2;

   typedef enum logic [1:0] {
      SBP_SPD_BASE,
      SBP_SPD_DOUBLE,
      SBP_SPD_QUAD
   } sbp_speed_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } sbp_reg_req_t;

   typedef struct packed {
      logic data;
      logic strobe;
      logic data_oe;
      logic strobe_oe;
   } sbp_pair_out_t;
endpackage

// >>> sbp_phy_core.sv
// serial bus phy datapath: ds coding, retiming, low power and stream hooks
`timescale 1ns/1ps
module sbp_phy_core
   import sbp_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int TS_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire sbp_reg_req_t reg_req,
   output logic [31:0] reg_rdata_q,
   input wire logic link_tx_bit,
   input wire logic link_tx_valid,
   input wire sbp_speed_t link_tx_speed,
   output logic link_rx_bit_q,
   output logic link_rx_valid_q,
   output logic link_clk_q,
   input wire logic twisted_pair_a_in,
   input wire logic twisted_pair_b_in,
   input wire logic pair_a_cm_high,
   input wire logic pair_a_cm_mid,
   input wire logic arb_cmp_a,
   input wire logic arb_cmp_b,
   output logic [1:0] arb_state_q,
   output sbp_speed_t next_speed_q,
   output logic rx_receiving_q,
   output logic pair_a_out_q,
   output logic pair_a_oe_q,
   output logic pair_b_out_q,
   output logic pair_b_oe_q,
   output logic rx_enable_q,
   input wire logic [1:0] power_state,
   input wire logic port_connected,
   input wire logic port_disabled,
   input wire logic port_suspended,
   input wire logic port_irq_enable,
   input wire logic ev_bias_suspended,
   input wire logic ev_disc_suspended,
   input wire logic ev_new_connect,
   output logic low_power_q,
   output logic deep_sleep_q,
   output logic ref_enable_q,
   output logic phy_ready_q,
   input wire logic [TS_W-1:0] cycle_timer,
   input wire logic tx_hdr_valid,
   input wire logic tx_is_stream,
   input wire logic [TS_W-1:0] sw_sync_ts,
   output logic [TS_W-1:0] tx_sync_ts_q,
   output logic tx_ts_inserted_q,
   input wire logic rx_quad_valid,
   input wire logic rx_is_video,
   input wire logic rx_pkt_start,
   output logic rx_quad_pass_q
);
   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   logic [31:0] hc_ctrl_q;
   logic [31:0] vse_q;
   wire wr_set = reg_req.wr && reg_req.addr == HC_CTRL_SET_OFS;
   wire wr_clr = reg_req.wr && reg_req.addr == HC_CTRL_CLR_OFS;
   wire wr_vse = reg_req.wr && reg_req.addr == VSE_OFS;
   wire sel_hc = reg_req.addr == HC_CTRL_OFS || reg_req.addr == HC_CTRL_CLR_OFS;
   wire sel_vse = reg_req.addr == VSE_OFS;
   wire [31:0] rd_mux = sel_hc ? hc_ctrl_q : (sel_vse ? vse_q : 32'h0000_0000);
   wire wake_req = hc_ctrl_q[LPR_BIT];
   wire ts_en = vse_q[VSE_TS_BIT];
   wire strip_en = vse_q[VSE_STRIP_BIT];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hc_ctrl_q <= HC_CTRL_RST;
         vse_q <= VSE_RST;
         reg_rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         // set-on-write at 50h, clear-on-write at 54h
         if (wr_set)
            hc_ctrl_q <= hc_ctrl_q | reg_req.wdata;
         else if (wr_clr)
            hc_ctrl_q <= hc_ctrl_q & ~reg_req.wdata;
         if (wr_vse)
            vse_q <= reg_req.wdata;
         if (reg_req.rd)
            reg_rdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // power control
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PW_ACTIVE,
      PW_SLEEP,
      PW_WAKING
   } sbp_pw_t;
   sbp_pw_t pw_q;
   logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_q;
   wire port_idle = !port_connected || port_disabled || port_suspended;
   wire in_low_state = power_state >= 2'd2;
   wire port_event = (ev_bias_suspended && port_suspended) || (ev_disc_suspended && port_suspended)
      || (ev_new_connect && !port_disabled);
   wire deep_ok = (!port_connected || port_disabled) && !port_irq_enable;
   wire wake_any = wake_req || port_event;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pw_q <= PW_ACTIVE;
         wake_cnt_q <= '0;
         low_power_q <= 1'b0;
         deep_sleep_q <= 1'b0;
         ref_enable_q <= 1'b1;
         phy_ready_q <= 1'b1;
      end else if (clk_en) begin
         case (pw_q)
            PW_ACTIVE: begin
               if (in_low_state && port_idle && !wake_any) begin
                  pw_q <= PW_SLEEP;
                  low_power_q <= 1'b1;
                  phy_ready_q <= 1'b0;
                  ref_enable_q <= 1'b0;
                  deep_sleep_q <= deep_ok;
               end
            end
            PW_SLEEP: begin
               deep_sleep_q <= deep_ok;
               if (wake_any) begin
                  pw_q <= PW_WAKING;
                  wake_cnt_q <= '0;
                  ref_enable_q <= 1'b1;
                  deep_sleep_q <= 1'b0;
               end
            end
            PW_WAKING: begin
               // fixed settle well inside the bound
               if (wake_cnt_q == ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES - 1)) begin
                  pw_q <= PW_ACTIVE;
                  low_power_q <= 1'b0;
                  phy_ready_q <= 1'b1;
               end else
                  wake_cnt_q <= wake_cnt_q + 1'b1;
            end
            default: pw_q <= PW_ACTIVE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // link clock divider, gated while asleep
   // ------------------------------------------------------------
   logic [2:0] div_q;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_q <= 3'h0;
         link_clk_q <= 1'b0;
      end else if (clk_en) begin
         if (!phy_ready_q) begin
            // restart from phase zero so first pulse is full width
            div_q <= 3'h0;
            link_clk_q <= 1'b0;
         end else begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'(LINK_DIV/2 - 1) || div_q == 3'(LINK_DIV - 1))
               link_clk_q <= ~link_clk_q;
         end
      end
   end

   // ------------------------------------------------------------
   // transmit: capture, serialize, ds encode
   // ------------------------------------------------------------
   logic tx_bit_q;
   logic tx_active_q;
   logic [1:0] tx_tick_q;
   wire [1:0] tx_rate = link_tx_speed == SBP_SPD_QUAD ? 2'd0 :
      (link_tx_speed == SBP_SPD_DOUBLE ? 2'd1 : 2'd3);
   wire tx_tick = tx_tick_q == tx_rate;
   wire tx_go = phy_ready_q && link_tx_valid && !rx_receiving_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_bit_q <= 1'b0;
         tx_active_q <= 1'b0;
         tx_tick_q <= 2'd0;
         pair_a_out_q <= 1'b0;
         pair_b_out_q <= 1'b0;
         pair_a_oe_q <= 1'b0;
         pair_b_oe_q <= 1'b0;
      end else if (clk_en) begin
         tx_active_q <= tx_go;
         tx_tick_q <= tx_tick ? 2'd0 : tx_tick_q + 2'd1;
         if (tx_go && tx_tick)
            tx_bit_q <= link_tx_bit;
         if (tx_active_q && tx_tick) begin
            pair_b_out_q <= tx_bit_q;
            // strobe toggles when data repeats
            if (tx_bit_q == pair_b_out_q)
               pair_a_out_q <= ~pair_a_out_q;
         end
         pair_a_oe_q <= tx_active_q && !rx_receiving_q;
         pair_b_oe_q <= tx_active_q && !rx_receiving_q;
      end
   end

   // ------------------------------------------------------------
   // receive: ds decode and retime
   // ------------------------------------------------------------
   logic rx_d_q;
   logic rx_s_q;
   logic rx_d2_q;
   logic rx_s2_q;
   wire rx_edge = (rx_d2_q ^ rx_s2_q) != (rx_d_q ^ rx_s_q);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_d_q <= 1'b0;
         rx_s_q <= 1'b0;
         rx_d2_q <= 1'b0;
         rx_s2_q <= 1'b0;
         link_rx_bit_q <= 1'b0;
         link_rx_valid_q <= 1'b0;
         rx_receiving_q <= 1'b0;
         rx_enable_q <= 1'b1;
      end else if (clk_en) begin
         rx_receiving_q <= !tx_active_q && arb_cmp_a && phy_ready_q;
         rx_enable_q <= !tx_active_q;
         rx_d_q <= twisted_pair_a_in;
         rx_s_q <= twisted_pair_b_in;
         rx_d2_q <= rx_d_q;
         rx_s2_q <= rx_s_q;
         link_rx_valid_q <= rx_receiving_q && rx_edge;
         // pins are synchronous, so rx_d_q already holds the new bit
         if (rx_receiving_q && rx_edge)
            link_rx_bit_q <= rx_d_q;
      end
   end

   // ------------------------------------------------------------
   // arbitration line state and speed sensing
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arb_state_q <= 2'b00;
         next_speed_q <= SBP_SPD_BASE;
      end else if (clk_en) begin
         arb_state_q <= {arb_cmp_a, arb_cmp_b};
         if (!tx_active_q && !rx_receiving_q)
            next_speed_q <= pair_a_cm_high ? SBP_SPD_QUAD :
               (pair_a_cm_mid ? SBP_SPD_DOUBLE : SBP_SPD_BASE);
      end
   end

   // ------------------------------------------------------------
   // stream enhancements
   // ------------------------------------------------------------
   logic [1:0] cip_cnt_q;
   wire ts_stale = sw_sync_ts >= cycle_timer;
   wire [TS_W-1:0] ts_fixed = ts_stale ? cycle_timer - TS_W'(1) : sw_sync_ts;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_sync_ts_q <= '0;
         tx_ts_inserted_q <= 1'b0;
         cip_cnt_q <= 2'd0;
         rx_quad_pass_q <= 1'b0;
      end else if (clk_en) begin
         tx_ts_inserted_q <= tx_hdr_valid && tx_is_stream && ts_en;
         if (tx_hdr_valid)
            tx_sync_ts_q <= (ts_en && tx_is_stream) ? ts_fixed : sw_sync_ts;
         if (rx_pkt_start)
            cip_cnt_q <= 2'd0;
         else if (rx_quad_valid && cip_cnt_q != 2'(CIP_QUADS))
            cip_cnt_q <= cip_cnt_q + 2'd1;
         rx_quad_pass_q <= rx_quad_valid && !(strip_en && rx_is_video && !rx_pkt_start
            && cip_cnt_q != 2'(CIP_QUADS));
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_drivers_off_rx: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && $past(rx_receiving_q) && $past(clk_en) |-> !pair_a_oe_q && !pair_b_oe_q)
      else $error("drivers on while receiving");
   a_clk_held_sleep: assert property (@(posedge sys_clk) disable iff (rst)
      !phy_ready_q ##1 !phy_ready_q |-> !link_clk_q)
      else $error("link clock running asleep");
   a_sleep_entry: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && pw_q == PW_ACTIVE && in_low_state && port_idle && !wake_any |=> low_power_q)
      else $error("no sleep entry");
   a_wake_done: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && pw_q == PW_WAKING && int'(wake_cnt_q) == WAKE_CYCLES - 1 |=> phy_ready_q && !low_power_q)
      else $error("wake not finished in time");
   a_wake_count: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && pw_q == PW_WAKING && int'(wake_cnt_q) != WAKE_CYCLES - 1 |=> wake_cnt_q == $past(wake_cnt_q) + 1'b1)
      else $error("wake counter stalled");
   a_ts_not_stale: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && tx_hdr_valid && tx_is_stream && ts_en && cycle_timer != 0 |=> tx_sync_ts_q < $past(cycle_timer))
      else $error("stale timestamp");
   a_ts_gated: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && !ts_en |=> !tx_ts_inserted_q)
      else $error("timestamp insert while disabled");
   a_deep_cond: assert property (@(posedge sys_clk) disable iff (rst)
      deep_sleep_q |-> low_power_q)
      else $error("deep sleep while awake");
   a_refs_off_sleep: assert property (@(posedge sys_clk) disable iff (rst)
      pw_q == PW_SLEEP |-> !ref_enable_q)
      else $error("references on in sleep");
   a_ds_one_change: assert property (@(posedge sys_clk) disable iff (rst)
      $past(clk_en && tx_active_q && tx_tick)
      |-> (pair_a_out_q != $past(pair_a_out_q)) != (pair_b_out_q != $past(pair_b_out_q)))
      else $error("data and strobe not one change per bit");
   a_rx_valid_gate: assert property (@(posedge sys_clk) disable iff (rst)
      link_rx_valid_q |-> $past(rx_receiving_q))
      else $error("bit passed while not receiving");
   a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !clk_en |=> $stable(hc_ctrl_q) && $stable(vse_q) && $stable(link_clk_q))
      else $error("state moved while clock enable low");
endmodule

// >>> sbp_remote_node.sv
// model of the remote cable node sending one data-strobe coded byte
`timescale 1ns/1ps
module sbp_remote_node (
   input wire logic sys_clk,
   input wire logic send,
   input wire logic [7:0] pat,
   output logic pair_a,
   output logic pair_b
);
   logic ph;
   logic busy;
   int idx;
   initial begin
      {pair_a, pair_b, busy, ph} = '0;
      idx = 0;
   end
   // ----------------------------------------
   // bit sender, one bit every two cycles
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (send && !busy) begin
         busy <= 1'h1;
         ph <= 1'h0;
         idx <= 0;
      end else if (busy) begin
         ph <= ~ph;
         if (ph) begin
            // strobe flips only when data repeats
            pair_a <= pat[7 - idx];
            pair_b <= pair_b ^ (pat[7 - idx] == pair_a);
            idx <= idx + 1;
            busy <= (idx < 7);
         end
      end else if (!send) begin
         // idle data line never keeps its last level, strobe line holds
         pair_a <= ~pair_a;
      end
   end
endmodule

// >>> tb.sv
// testbench: registers, power, line coding and stream hooks
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c, n) begin for (wk = 0; wk < (n) && (c) !== 1'h1; wk++) cyc(1); \
   checked++; if ((c) !== 1'h1) begin fails++; give_verdict; end end
module tb
   import sbp_pkg::*;
;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic sys_clk, rst, clk_en, link_tx_bit, link_tx_valid, link_rx_bit_q, link_rx_valid_q, link_clk_q;
   logic pair_a_cm_high, pair_a_cm_mid, arb_cmp_a, arb_cmp_b, rx_receiving_q, pair_a_out_q, pair_a_oe_q;
   logic pair_b_out_q, pair_b_oe_q, rx_enable_q, port_connected, port_disabled, port_suspended;
   logic port_irq_enable, ev_bias_suspended, ev_disc_suspended, ev_new_connect, low_power_q, deep_sleep_q;
   logic ref_enable_q, phy_ready_q, tx_hdr_valid, tx_is_stream, tx_ts_inserted_q, rx_quad_valid;
   logic rx_is_video, rx_pkt_start, rx_quad_pass_q, twisted_pair_a_in, twisted_pair_b_in, rx_send;
   logic [1:0] arb_state_q, power_state;
   logic [7:0] rx_pat;
   logic [15:0] cycle_timer, sw_sync_ts, tx_sync_ts_q;
   logic [31:0] reg_rdata_q;
   sbp_reg_req_t reg_req;
   sbp_speed_t link_tx_speed, next_speed_q;
   int fails, checked, wk;

   sbp_phy_core #(.WAKE_CYCLES(8)) i_sbp_phy_core (.sys_clk, .rst, .clk_en, .reg_req, .reg_rdata_q,
      .link_tx_bit, .link_tx_valid, .link_tx_speed, .link_rx_bit_q, .link_rx_valid_q, .link_clk_q,
      .twisted_pair_a_in, .twisted_pair_b_in, .pair_a_cm_high, .pair_a_cm_mid, .arb_cmp_a, .arb_cmp_b,
      .arb_state_q, .next_speed_q, .rx_receiving_q, .pair_a_out_q, .pair_a_oe_q, .pair_b_out_q,
      .pair_b_oe_q, .rx_enable_q, .power_state, .port_connected, .port_disabled, .port_suspended,
      .port_irq_enable, .ev_bias_suspended, .ev_disc_suspended, .ev_new_connect, .low_power_q,
      .deep_sleep_q, .ref_enable_q, .phy_ready_q, .cycle_timer, .tx_hdr_valid, .tx_is_stream,
      .sw_sync_ts, .tx_sync_ts_q, .tx_ts_inserted_q, .rx_quad_valid, .rx_is_video, .rx_pkt_start,
      .rx_quad_pass_q);
   sbp_remote_node i_sbp_remote_node (.sys_clk, .send(rx_send), .pat(rx_pat),
      .pair_a(twisted_pair_a_in), .pair_b(twisted_pair_b_in));

   initial begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_req.wr = 1'h1;
      reg_req.addr = a;
      reg_req.wdata = d;
      cyc(1);
      reg_req.wr = 1'h0;
      cyc(1);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      reg_req.rd = 1'h1;
      reg_req.addr = a;
      cyc(1);
      reg_req.rd = 1'h0;
      `CHK(reg_rdata_q, e)
      cyc(1);
   endtask
   task automatic tog(input bit s, input int n, output int t);
      logic p;
      t = 0;
      repeat (n) begin
         p = s ? pair_a_out_q : link_clk_q;
         cyc(1);
         t += ((s ? pair_a_out_q : link_clk_q) !== p);
      end
   endtask
   task automatic ts(input logic [15:0] c, s, input logic st, ei, input logic [15:0] e);
      cycle_timer = c;
      sw_sync_ts = s;
      tx_is_stream = st;
      tx_hdr_valid = 1'h1;
      cyc(1);
      tx_hdr_valid = 1'h0;
      `CHK(tx_ts_inserted_q, ei)
      `CHK(tx_sync_ts_q, e)
      cyc(1);
   endtask
   task automatic pk(input logic v);
      rx_is_video = v;
      rx_pkt_start = 1'h1;
      cyc(1);
      rx_pkt_start = 1'h0;
   endtask
   task automatic q(input logic e);
      rx_quad_valid = 1'h1;
      cyc(1);
      rx_quad_valid = 1'h0;
      `CHK(rx_quad_pass_q, e)
      cyc(1);
   endtask
   task automatic give_verdict;
      if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reg;
      int t;
      `CHK({rx_enable_q, phy_ready_q}, 2'h3)
      `CHK(next_speed_q, SBP_SPD_BASE)
      rdc(HC_CTRL_OFS, HC_CTRL_RST);
      rdc(VSE_OFS, VSE_RST);
      wr(12'h100, 32'hffff_ffff);
      rdc(12'h100, 32'h0);
      wr(HC_CTRL_SET_OFS, 32'h0008_0000);
      rdc(HC_CTRL_CLR_OFS, 32'h0008_0000);
      wr(HC_CTRL_CLR_OFS, 32'h0008_0000);
      rdc(HC_CTRL_OFS, 32'h0);
      wr(VSE_OFS, 32'h3);
      rdc(VSE_OFS, 32'h3);
      tog(1'h0, 16, t);
      `CHK(t, 4)
      clk_en = 1'h0;
      wr(VSE_OFS, 32'h0);
      tog(1'h0, 8, t);
      `CHK(t, 0)
      clk_en = 1'h1;
      rdc(VSE_OFS, 32'h3);
   endtask
   task automatic t_arb;
      for (int k = 0; k < 3; k++) begin
         pair_a_cm_mid = (k == 1);
         pair_a_cm_high = (k == 2);
         cyc(2);
         `CHK(next_speed_q, sbp_speed_t'(k))
      end
      arb_cmp_b = 1'h1;
      cyc(2);
      `CHK(arb_state_q, 2'h1)
      arb_cmp_b = 1'h0;
   endtask
   task automatic t_tx;
      int t;
      link_tx_bit = 1'h1;
      link_tx_valid = 1'h1;
      `WT(pair_b_oe_q, 10)
      for (int k = 0; k < 3; k++) begin
         link_tx_speed = sbp_speed_t'(k);
         cyc(8);
         `CHK({pair_b_out_q, pair_a_oe_q}, 2'h3)
         tog(1'h1, 8, t);
         `CHK(t, 8 >> (2 - k))
      end
      link_tx_bit = 1'h0;
      cyc(4);
      `CHK(pair_b_out_q, 1'h0)
      link_tx_valid = 1'h0;
      cyc(4);
   endtask
   task automatic t_rx;
      logic [7:0] got;
      int n;
      n = 0;
      got = 8'h0;
      rx_pat = 8'hb4;
      rx_send = 1'h1;
      cyc(1);
      arb_cmp_a = 1'h1;
      rx_send = 1'h0;
      cyc(1);
      `CHK(rx_receiving_q, 1'h1)
      for (int i = 0; i < 40 && n < 8; i++) begin
         cyc(1);
         `CHK({pair_a_oe_q, pair_b_oe_q, rx_enable_q}, 3'h1)
         if (link_rx_valid_q === 1'h1) begin
            got = {got[6:0], link_rx_bit_q};
            n++;
         end
      end
      `CHK(got, 8'hb4)
      arb_cmp_a = 1'h0;
   endtask
   task automatic t_str;
      wr(VSE_OFS, 32'h1);
      ts(16'h0100, 16'h0200, 1'h1, 1'h1, 16'h00ff);
      ts(16'h0100, 16'h0050, 1'h1, 1'h1, 16'h0050);
      ts(16'h0100, 16'h0050, 1'h0, 1'h0, 16'h0050);
      wr(VSE_OFS, 32'h2);
      ts(16'h0100, 16'h0200, 1'h1, 1'h0, 16'h0200);
      pk(1'h1);
      for (int i = 0; i < 4; i++) q(i > 1);
      pk(1'h0);
      q(1'h1);
      wr(VSE_OFS, 32'h0);
      pk(1'h1);
      q(1'h1);
   endtask
   task automatic t_pwr;
      int t;
      port_irq_enable = 1'h1;
      power_state = 2'h3;
      `WT(low_power_q, 10)
      cyc(2);
      `CHK({deep_sleep_q, phy_ready_q}, 2'h0)
      tog(1'h0, 8, t);
      `CHK(t, 0)
      `CHK(link_clk_q, 1'h0)
      port_irq_enable = 1'h0;
      `WT(deep_sleep_q, 10)
      `CHK(ref_enable_q, 1'h0)
      wr(HC_CTRL_SET_OFS, 32'h0008_0000);
      `WT(phy_ready_q, 20)
      cyc(8);
      `CHK(low_power_q, 1'h0)
      {port_connected, port_suspended} = 2'h3;
      wr(HC_CTRL_CLR_OFS, 32'h0008_0000);
      `WT(low_power_q, 10)
      cyc(2);
      `CHK(deep_sleep_q, 1'h0)
      ev_bias_suspended = 1'h1;
      cyc(1);
      ev_bias_suspended = 1'h0;
      `WT(ref_enable_q, 4)
      `WT(!low_power_q, 20)
      power_state = 2'h0;
      `WT(phy_ready_q, 20)
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {reg_req, link_tx_bit, link_tx_valid, pair_a_cm_high, pair_a_cm_mid, arb_cmp_a, arb_cmp_b} = '0;
      {power_state, port_connected, port_disabled, port_suspended, port_irq_enable, rx_send} = '0;
      {ev_bias_suspended, ev_disc_suspended, ev_new_connect, tx_hdr_valid, tx_is_stream} = '0;
      {sw_sync_ts, rx_quad_valid, rx_is_video, rx_pkt_start, rx_pat} = '0;
      link_tx_speed = SBP_SPD_BASE;
      cycle_timer = 16'h0100;
      clk_en = 1'h1;
      rst = 1'h1;
      fails = 0;
      checked = 0;
      cyc(2);
      rst = 1'h0;
      t_reg;
      t_arb;
      t_tx;
      t_rx;
      t_str;
      t_pwr;
      give_verdict;
   end
endmodule
